// ===== dv/phy_power_mode_control_bench.sv
// Self-checking bench of the power-mode block driven through the host model.
`timescale 1ns/1ps
`include "ppm_params.svh"
module phy_power_mode_control_bench;
  import ppm_pkg::*;
  localparam int LPN = 20;
  localparam int LPE = 80;
  logic          ref_clk;
  logic          rst_b = 1'b0;
  ppm_mgmt_req_t mgmt_req;
  logic          link_up = 1'b0;
  logic          energy_a = 1'b0;
  logic          energy_b = 1'b0;
  logic          core_supply_on = 1'b1;
  logic   [15:0] mgmt_rdata;
  logic          mgmt_rvalid;
  ppm_pwr_ctl_t  pwr;
  logic          line_energy_indicator;
  logic          link_pulse;
  logic          soft_reset;
  logic          sleep_active;
  logic          sr_seen = 1'b0;
  logic   [15:0] rdv;
  logic          rok;
  int            num_errors = 0;
  int            cmp_count = 0;
  int            cyc = 0;

  ppm_top #(.LP_NORMAL_CYC(24'(LPN)), .LP_ENERGY_DETECT_POWER_DOWN_CYC(24'(LPE))) i_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .mgmt_req(mgmt_req), .link_up(link_up),
    .energy_a(energy_a), .energy_b(energy_b), .core_supply_on(core_supply_on),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .pwr(pwr),
    .line_energy_indicator(line_energy_indicator), .link_pulse(link_pulse),
    .soft_reset(soft_reset), .sleep_active(sleep_active)
  );

  ppm_host_model i_host (
    .ref_clk(ref_clk), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    if (soft_reset === 1'b1)
      sr_seen <= 1'b1;
    cyc++;
    if (cyc == 12000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    i_host.rd(a, rdv, rok);
    chk_bit(rok, 1'b1);
    chk_word(rdv, exp);
  endtask : rd_chk

  // Selector 1 watches sleep_active, 0 the energy indicator.
  task automatic wait_out(input int sel, input logic v, input int lim);
    logic s;
    for (int i = 0; i < lim; i++)
    begin
      s = (sel == 1) ? sleep_active : line_energy_indicator;
      if (s === v)
        break;
      step(1);
    end
    chk_bit(s, v);
  endtask : wait_out

  task automatic gap_chk(input int exp);
    int n;
    n = 0;
    while (link_pulse !== 1'b1 && n < 400)
    begin
      step(1);
      n++;
    end
    n = 0;
    step(1);
    while (link_pulse !== 1'b1 && n < 400)
    begin
      step(1);
      n++;
    end
    chk_word(16'(n + 1), 16'(exp));
  endtask : gap_chk

  task automatic hw_reset();
    rst_b = 1'b0;
    step(3);
    rst_b = 1'b1;
  endtask : hw_reset

  task automatic core_cycle();
    core_supply_on = 1'b0;
    step(2);
    core_supply_on = 1'b1;
    step(2);
  endtask : core_cycle

  task automatic end_test(input string name);
    $display("Test %s finished, errors so far %0d", name, num_errors);
  endtask : end_test

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial
  begin
    hw_reset();
    chk_bit(line_energy_indicator, 1'b1);
    rd_chk(`PPM_REG_SLEEP, 16'h0000);
    rd_chk(`PPM_REG_EXPCTL, 16'h0800);
    rd_chk(`PPM_REG_PHYCTL2, 16'h0000);
    rd_chk(5'h05, 16'h0000);
    chk_bit(pwr.rx_on, 1'b1);
    end_test("defaults");
    i_host.wr(`PPM_REG_PHYCTL2, 16'h0400);
    step(1);
    chk_word({9'h000, pwr}, 16'h003f);
    link_up = 1'b1;
    step(2);
    chk_bit(pwr.rx_on, 1'b1);
    link_up = 1'b0;
    gap_chk(LPN);
    i_host.wr(`PPM_REG_PHYCTL2, 16'h0000);
    i_host.wr(`PPM_REG_EXPCTL, 16'h0000);
    step(1);
    chk_bit(pwr.rx_on, 1'b0);
    chk_bit(pwr.pll_on, 1'b1);
    gap_chk(LPE);
    i_host.wr(`PPM_REG_DIGCTL, 16'h0010);
    step(1);
    chk_bit(pwr.pll_on, 1'b0);
    chk_bit(pwr.tx_on & pwr.energy_det_on, 1'b1);
    end_test("saving_modes");
    i_host.wr(`PPM_REG_EXPCTL, 16'h0800);
    i_host.wr(`PPM_REG_BASIC, 16'h3800);
    step(1);
    chk_bit(pwr.rx_on, 1'b0);
    chk_bit(pwr.mgmt_on, 1'b1);
    i_host.wr(`PPM_REG_AFE0, 16'h0040);
    step(1);
    chk_bit(pwr.ref_clk_connect, 1'b0);
    i_host.exit_slow_pd();
    step(2);
    chk_bit(sr_seen, 1'b1);
    rd_chk(`PPM_REG_BASIC, 16'h3000);
    rd_chk(`PPM_REG_DIGCTL, 16'h0000);
    chk_bit(pwr.ref_clk_connect & pwr.rx_on, 1'b1);
    end_test("power_down");
    i_host.wr(`PPM_REG_SLEEP, 16'h0002);
    core_cycle();
    rd_chk(`PPM_REG_SLEEP, 16'h0000);
    i_host.wr(`PPM_REG_SLEEP, 16'h0012);
    i_host.wr(`PPM_REG_AFE2, 16'h0303);
    core_cycle();
    rd_chk(`PPM_REG_SLEEP, 16'h0012);
    rd_chk(`PPM_REG_AFE2, 16'h0303);
    hw_reset();
    rd_chk(`PPM_REG_SLEEP, 16'h0000);
    rd_chk(`PPM_REG_AFE2, 16'h0000);
    end_test("always_on_copies");
    i_host.init_cpu();
    wait_out(0, 1'b0, 5);
    energy_b = 1'b1;
    wait_out(0, 1'b1, 4);
    energy_b = 1'b0;
    step(40);
    chk_bit(line_energy_indicator, 1'b1);
    wait_out(0, 1'b0, 20);
    i_host.wr(`PPM_REG_SLEEP, 16'h0059);
    chk_bit(line_energy_indicator, 1'b1);
    i_host.wr(`PPM_REG_SLEEP, 16'h0058);
    i_host.wr(`PPM_REG_AFE2, 16'h0001);
    i_host.enter_sleep();
    wait_out(1, 1'b1, 4);
    chk_bit(pwr.io_on | pwr.tx_on, 1'b0);
    chk_bit(pwr.mgmt_on, 1'b1);
    chk_bit(pwr.ref_clk_connect, 1'b0);
    rd_chk(`PPM_REG_SLEEP, 16'h0078);
    i_host.wr(`PPM_REG_SLEEP, 16'h0058);
    wait_out(1, 1'b0, 4);
    i_host.wr(`PPM_REG_AFE2, 16'h0000);
    i_host.enter_sleep();
    wait_out(1, 1'b1, 4);
    chk_bit(pwr.mgmt_on, 1'b0);
    i_host.rd(`PPM_REG_SLEEP, rdv, rok);
    chk_bit(rok, 1'b0);
    i_host.wr(`PPM_REG_SLEEP, 16'h0058);
    step(3);
    chk_bit(sleep_active, 1'b1);
    hw_reset();
    chk_bit(sleep_active, 1'b0);
    end_test("cpu_sleep");
    i_host.init_auto();
    wait_out(1, 1'b1, 6);
    chk_bit(line_energy_indicator, 1'b0);
    energy_a = 1'b1;
    wait_out(1, 1'b0, 6);
    chk_bit(line_energy_indicator, 1'b1);
    energy_a = 1'b0;
    step(2400);
    chk_bit(sleep_active, 1'b0);
    wait_out(1, 1'b1, 200);
    end_test("auto_sleep");
    wrap_up();
  end
endmodule : phy_power_mode_control_bench

// ===== dv/ppm_host_model.sv
// Host CPU model: issues management register requests and the host-side power sequences.
`timescale 1ns/1ps
`include "ppm_params.svh"
module ppm_host_model (
  input  wire logic             ref_clk,
  output ppm_pkg::ppm_mgmt_req_t mgmt_req,
  input  wire logic      [15:0] mgmt_rdata,
  input  wire logic             mgmt_rvalid
);
  import ppm_pkg::*;

  initial mgmt_req = '0;

  // One idle cycle follows each write so that strobes never toggle twice in a time step.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mgmt_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    #1;
    mgmt_req = '0;
    @(posedge ref_clk);
    #1;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
    mgmt_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge ref_clk);
    #1;
    mgmt_req = '0;
    ok = mgmt_rvalid;
    d = mgmt_rdata;
    @(posedge ref_clk);
    #1;
  endtask : rd

  task automatic init_cpu();
    wr(`PPM_REG_SLEEP, 16'h0058);
  endtask : init_cpu

  task automatic init_auto();
    wr(`PPM_REG_SLEEP, 16'h001a);
  endtask : init_auto

  task automatic enter_sleep();
    wr(`PPM_REG_SLEEP, 16'h0078);
  endtask : enter_sleep

  task automatic exit_slow_pd();
    wr(`PPM_REG_AFE0, 16'h0000);
    wr(`PPM_REG_BASIC, 16'h3000);
    wr(`PPM_REG_BASIC, 16'hb000);
  endtask : exit_slow_pd
endmodule : ppm_host_model

// ===== inc/ppm_params.svh
// Register offsets, field positions, reset values and timing figures of the power-mode block.
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH
`define PPM_REG_BASIC        5'h00
`define PPM_REG_DIGCTL       5'h10
`define PPM_REG_AFE0         5'h11
`define PPM_REG_AFE2         5'h13
`define PPM_REG_SLEEP        5'h14
`define PPM_REG_EXPCTL       5'h18
`define PPM_REG_PHYCTL2      5'h1f
`define PPM_BASIC_SWRST      15
`define PPM_BASIC_AN_EN      12
`define PPM_BASIC_PDOWN      11
`define PPM_DIG_PLL_OFF      4
`define PPM_AFE0_SLOW_OSC    6
`define PPM_AFE2_SLOW_OSC    0
`define PPM_SL_CPU_MODE      6
`define PPM_SL_ENTER         5
`define PPM_SL_SHADOW        4
`define PPM_SL_ENABLE        3
`define PPM_SL_EXT_TIME      1
`define PPM_SL_POLARITY      0
`define PPM_EXP_ENERGY_DETECT_POWER_DOWN_DIS     11
`define PPM_PC2_PSAVE        10
`define PPM_AFE2_KEEP_MASK   16'h0303
`define PPM_DEF_BASIC        16'h3000
`define PPM_DEF_DIGCTL       16'h0000
`define PPM_DEF_AFE0         16'h0000
`define PPM_DEF_AFE2         16'h0000
`define PPM_DEF_SLEEP        16'h0000
`define PPM_DEF_EXPCTL       16'h0800
`define PPM_DEF_PHYCTL2      16'h0000
`define PPM_CLK_PERIOD_NS    20
`define PPM_DEASSERT_NS      1000
`define PPM_DEASSERT_EXT_NS  50000
`define PPM_LP_NORMAL_NS     16000000
`define PPM_LP_ENERGY_DETECT_POWER_DOWN_NS       64000000
`define PPM_CYC_UP(ns)       (((ns) + `PPM_CLK_PERIOD_NS - 1) / `PPM_CLK_PERIOD_NS)
`define PPM_CYC_DN(ns)       ((ns) / `PPM_CLK_PERIOD_NS)
`endif

// ===== inc/ppm_pkg.sv
// Types shared by the power-mode block and its submodules.
package ppm_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } ppm_mgmt_req_t;

  typedef struct packed {
    logic rx_on;
    logic tx_on;
    logic energy_det_on;
    logic pll_on;
    logic mgmt_on;
    logic io_on;
    logic ref_clk_connect;
  } ppm_pwr_ctl_t;

  typedef enum logic [0:0] {
    ST_RUN,
    ST_SLEEP
  } ppm_state_t;
endpackage : ppm_pkg

// ===== rtl/ppm_pulse_timer.sv
// Free-running link pulse interval timer with two selectable periods.
`timescale 1ns/1ps
module ppm_pulse_timer (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        long_sel,
  input  wire logic [23:0] short_cyc,
  input  wire logic [23:0] long_cyc,
  output logic             tick
);
  logic [23:0] count;
  logic [23:0] limit;

  assign limit = long_sel ? long_cyc : short_cyc;

  // A shortened period takes effect at once because the compare is not exact.
  always_ff @(posedge ref_clk)
    if (!rst_b)
    begin
      count <= 24'h000000;
      tick  <= 1'b0;
    end
    else if (count >= limit - 24'h000001)
    begin
      count <= 24'h000000;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 24'h000001;
      tick  <= 1'b0;
    end
endmodule : ppm_pulse_timer

// ===== rtl/ppm_shadow.sv
// Always-on copies of the sleep control word and the kept oscillator/AFE bits.
`timescale 1ns/1ps
`include "ppm_params.svh"
module ppm_shadow (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        wr_sleep,
  input  wire logic        wr_afe2,
  input  wire logic [15:0] wdata,
  output logic      [15:0] sh_sleep,
  output logic      [15:0] sh_afe2
);
  import ppm_pkg::*;

  // Only a hardware reset clears these; the core supply going away does not.
  always_ff @(posedge ref_clk)
    if (!rst_b)
      sh_sleep <= `PPM_DEF_SLEEP;
    else if (wr_sleep)
      sh_sleep <= wdata;

  always_ff @(posedge ref_clk)
    if (!rst_b)
      sh_afe2 <= `PPM_DEF_AFE2;
    else if (wr_afe2)
      sh_afe2 <= wdata & `PPM_AFE2_KEEP_MASK;
endmodule : ppm_shadow

// ===== rtl/ppm_top.sv
// Power-mode control of the transceiver: saving modes, power down and ultra-deep sleep.
//
// Function
// [R1] Power saving enabled by 1Fh[10], active only with auto-negotiation on and no link.
// [R2] Power saving leaves only transmitter, energy detector and PLL running; off after reset.
// [R3] Energy-detect power down enabled by 18h[11]=0, needs auto-negotiation and no link.
// [R4] With 10h[4] set during energy-detect power down the PLL is also off.
// [R5] Energy-detect power down keeps sending link pulses at a longer interval.
// [R6] 0h[11] disables everything but management; clearing it resumes operation.
// [R7] 11h[6] disconnects the reference clock input and selects the slow oscillator.
// [R8] Host leaves slow oscillator power down: clear 11h[6], clear 0h[11], then reset.
// [R9] Ultra-deep sleep keeps only detector and indicator; hardware reset exits it.
// [R10] Always-on copies of 14h and 13h bits change only with 14h[4] set.
// [R11] Indicator asserts with energy on either pair, deasserts when energy is gone.
// [R12] 14h: bit6 method, bit5 manual entry, bit3 enable, bit1 timing, bit0 polarity.
// [R13] Host sets shadow access with sleep enable; it also covers 13h[9:8] and [1:0].
// [R14] Indicator is driven high from power-on until the host enables it.
// [R15] Host writes 0x0058 to 14h to choose CPU-controlled sleep.
// [R16] Under CPU control host sets 14h[5] on deassertion; device then sleeps.
// [R17] Core powered and 13h[0] set keep management access; writing 14h ends sleep.
// [R18] Host writes 0x001A or 0x0018 to 14h to choose automatic sleep.
// [R19] Host sets extended timing in automatic mode except one forced 100 Mbps case.
// [R20] Automatic mode sleeps and deasserts on signal loss, wakes on signal return.
// [R21] 14h and 13h kept bits survive sleep but return to defaults on hardware reset.
`timescale 1ns/1ps
`include "ppm_params.svh"
module ppm_top #(
  parameter logic [23:0] LP_NORMAL_CYC  = 24'(`PPM_CYC_DN(`PPM_LP_NORMAL_NS)),
  parameter logic [23:0] LP_ENERGY_DETECT_POWER_DOWN_CYC    = 24'(`PPM_CYC_DN(`PPM_LP_ENERGY_DETECT_POWER_DOWN_NS))
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  input  wire ppm_pkg::ppm_mgmt_req_t mgmt_req,
  input  wire logic                   link_up,
  input  wire logic                   energy_a,
  input  wire logic                   energy_b,
  input  wire logic                   core_supply_on,
  output logic                 [15:0] mgmt_rdata,
  output logic                        mgmt_rvalid,
  output ppm_pkg::ppm_pwr_ctl_t       pwr,
  output logic                        line_energy_indicator,
  output logic                        link_pulse,
  output logic                        soft_reset,
  output logic                        sleep_active
);
  import ppm_pkg::*;

  localparam logic [11:0] DEASSERT_CYC = 12'(`PPM_CYC_UP(`PPM_DEASSERT_NS));
  localparam logic [11:0] DEASSERT_EXT_CYC = 12'(`PPM_CYC_UP(`PPM_DEASSERT_EXT_NS));

  function automatic logic reg_hit(input ppm_mgmt_req_t r, input logic [4:0] a);
    return r.addr == a;
  endfunction : reg_hit

  ppm_state_t   state;
  ppm_pwr_ctl_t next_pwr;
  logic [15:0]  basic;
  logic [15:0]  digctl;
  logic [15:0]  afe0;
  logic [15:0]  afe2;
  logic [15:0]  sleep_ctl;
  logic [15:0]  expctl;
  logic [15:0]  phyctl2;
  logic [15:0]  sh_sleep;
  logic [15:0]  sh_afe2;
  logic [15:0]  next_rdata;
  logic [11:0]  quiet_cnt;
  logic [11:0]  quiet_limit;
  logic         keep_access;
  logic         acc_ok;
  logic         wr;
  logic         wr_sleep;
  logic         energy;
  logic         detect;
  logic         an_nolink;
  logic         psave;
  logic         energy_detect_power_down;
  logic         lp_tick;
  logic         cpu_mode;
  logic         sleep_en;

  // Management reaches the registers only while the core is up, and in sleep only
  // when the slow oscillator keeps the register file clocked.
  assign keep_access = afe2[`PPM_AFE2_SLOW_OSC];
  assign acc_ok      = core_supply_on && (state == ST_RUN || keep_access); // [R17]
  assign wr          = mgmt_req.wr && acc_ok;
  assign wr_sleep    = wr && reg_hit(mgmt_req, `PPM_REG_SLEEP);
  assign cpu_mode    = sleep_ctl[`PPM_SL_CPU_MODE]; // [R12]
  assign sleep_en    = sleep_ctl[`PPM_SL_ENABLE]; // [R12]
  assign energy      = energy_a || energy_b;
  assign an_nolink   = basic[`PPM_BASIC_AN_EN] && !link_up;
  assign psave       = phyctl2[`PPM_PC2_PSAVE] && an_nolink; // [R1]
  assign energy_detect_power_down        = !expctl[`PPM_EXP_ENERGY_DETECT_POWER_DOWN_DIS] && an_nolink; // [R3]

  // Volatile registers are lost with the core supply; the kept bits come back
  // from the always-on copies so that the sleep setup survives.
  always_ff @(posedge ref_clk)
    if (!rst_b || !core_supply_on || soft_reset)
      basic <= `PPM_DEF_BASIC;
    else if (wr && reg_hit(mgmt_req, `PPM_REG_BASIC))
      basic <= mgmt_req.wdata & ~(16'h0001 << `PPM_BASIC_SWRST);

  always_ff @(posedge ref_clk)
    if (!rst_b || !core_supply_on || soft_reset)
      digctl <= `PPM_DEF_DIGCTL;
    else if (wr && reg_hit(mgmt_req, `PPM_REG_DIGCTL))
      digctl <= mgmt_req.wdata;

  always_ff @(posedge ref_clk)
    if (!rst_b || !core_supply_on || soft_reset)
      afe0 <= `PPM_DEF_AFE0;
    else if (wr && reg_hit(mgmt_req, `PPM_REG_AFE0))
      afe0 <= mgmt_req.wdata;

  always_ff @(posedge ref_clk)
    if (!rst_b || !core_supply_on || soft_reset)
      expctl <= `PPM_DEF_EXPCTL;
    else if (wr && reg_hit(mgmt_req, `PPM_REG_EXPCTL))
      expctl <= mgmt_req.wdata;

  always_ff @(posedge ref_clk)
    if (!rst_b || !core_supply_on || soft_reset)
      phyctl2 <= `PPM_DEF_PHYCTL2;
    else if (wr && reg_hit(mgmt_req, `PPM_REG_PHYCTL2))
      phyctl2 <= mgmt_req.wdata;

  always_ff @(posedge ref_clk)
    if (!rst_b)
      sleep_ctl <= `PPM_DEF_SLEEP; // [R21]
    else if (!core_supply_on)
      sleep_ctl <= sh_sleep; // [R21]
    else if (wr_sleep)
      sleep_ctl <= mgmt_req.wdata;

  always_ff @(posedge ref_clk)
    if (!rst_b)
      afe2 <= `PPM_DEF_AFE2; // [R21]
    else if (!core_supply_on)
      afe2 <= sh_afe2; // [R21]
    else if (wr && reg_hit(mgmt_req, `PPM_REG_AFE2))
      afe2 <= mgmt_req.wdata;

  // The access bit may arrive in the same write that sets it, so a single write
  // of the documented init word reaches the always-on copy.
  ppm_shadow u_shadow (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .wr_sleep (wr_sleep && (mgmt_req.wdata[`PPM_SL_SHADOW] || sleep_ctl[`PPM_SL_SHADOW])), // [R10]
    .wr_afe2  (wr && reg_hit(mgmt_req, `PPM_REG_AFE2) && sleep_ctl[`PPM_SL_SHADOW]), // [R10]
    .wdata    (mgmt_req.wdata),
    .sh_sleep (sh_sleep),
    .sh_afe2  (sh_afe2)
  );

  always_ff @(posedge ref_clk)
    if (!rst_b)
      soft_reset <= 1'b0;
    else
      soft_reset <= wr && reg_hit(mgmt_req, `PPM_REG_BASIC) && mgmt_req.wdata[`PPM_BASIC_SWRST];

  // Energy detect: assertion is immediate, deassertion waits for a quiet period
  // so that gaps between link pulses do not drop the indicator.
  assign quiet_limit = sleep_ctl[`PPM_SL_EXT_TIME] ? DEASSERT_EXT_CYC : DEASSERT_CYC; // [R12]

  always_ff @(posedge ref_clk)
    if (!rst_b)
    begin
      detect    <= 1'b0;
      quiet_cnt <= 12'h000;
    end
    else if (energy)
    begin
      detect    <= 1'b1; // [R11]
      quiet_cnt <= 12'h000;
    end
    else if (detect && quiet_cnt >= quiet_limit - 12'h001)
    begin
      detect    <= 1'b0; // [R11]
      quiet_cnt <= 12'h000;
    end
    else if (detect)
      quiet_cnt <= quiet_cnt + 12'h001;

  always_ff @(posedge ref_clk)
    if (!rst_b)
      line_energy_indicator <= 1'b1; // [R14]
    else if (!sleep_en)
      line_energy_indicator <= 1'b1; // [R14]
    else
      line_energy_indicator <= detect ^ sleep_ctl[`PPM_SL_POLARITY]; // [R11]

  // CPU-controlled sleep entry is taken from the write event, so a manual entry bit left at one
  // does not put the device straight back to sleep after a wake-up write.
  always_ff @(posedge ref_clk)
    if (!rst_b)
      state <= ST_RUN; // [R9]
    else
      case (state)
        ST_RUN:
          if (sleep_en && cpu_mode && wr_sleep && mgmt_req.wdata[`PPM_SL_ENTER])
            state <= ST_SLEEP; // [R16]
          else if (sleep_en && !cpu_mode && !detect)
            state <= ST_SLEEP; // [R20]
        ST_SLEEP:
          if (!cpu_mode && detect)
            state <= ST_RUN; // [R20]
          else if (cpu_mode && wr_sleep)
            state <= ST_RUN; // [R17]
        default:
          state <= ST_RUN;
      endcase

  always_comb
  begin
    next_pwr.io_on           = state == ST_RUN; // [R9]
    next_pwr.mgmt_on         = state == ST_RUN || (keep_access && core_supply_on); // [R17]
    next_pwr.tx_on           = state == ST_RUN && !basic[`PPM_BASIC_PDOWN]; // [R6]
    next_pwr.energy_det_on   = next_pwr.tx_on;
    next_pwr.pll_on          = next_pwr.tx_on && !(energy_detect_power_down && digctl[`PPM_DIG_PLL_OFF]); // [R4]
    next_pwr.rx_on           = next_pwr.tx_on && !psave && !energy_detect_power_down; // [R2]
    next_pwr.ref_clk_connect = !afe0[`PPM_AFE0_SLOW_OSC] && !(state == ST_SLEEP && keep_access); // [R7]
  end

  always_ff @(posedge ref_clk)
    if (!rst_b)
      pwr <= '0;
    else
      pwr <= next_pwr;

  always_ff @(posedge ref_clk)
    if (!rst_b)
      sleep_active <= 1'b0;
    else
      sleep_active <= state == ST_SLEEP;

  ppm_pulse_timer u_lp_timer (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .long_sel  (energy_detect_power_down), // [R5]
    .short_cyc (LP_NORMAL_CYC),
    .long_cyc  (LP_ENERGY_DETECT_POWER_DOWN_CYC),
    .tick      (lp_tick)
  );

  always_ff @(posedge ref_clk)
    if (!rst_b)
      link_pulse <= 1'b0;
    else
      link_pulse <= lp_tick && next_pwr.tx_on && !link_up; // [R5]

  always_comb
  begin
    case (mgmt_req.addr)
      `PPM_REG_BASIC:   next_rdata = basic;
      `PPM_REG_DIGCTL:  next_rdata = digctl;
      `PPM_REG_AFE0:    next_rdata = afe0;
      `PPM_REG_AFE2:    next_rdata = afe2;
      `PPM_REG_SLEEP:   next_rdata = sleep_ctl;
      `PPM_REG_EXPCTL:  next_rdata = expctl;
      `PPM_REG_PHYCTL2: next_rdata = phyctl2;
      default:          next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk)
    if (!rst_b)
    begin
      mgmt_rdata  <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end
    else
    begin
      mgmt_rdata  <= (mgmt_req.rd && acc_ok) ? next_rdata : 16'h0000;
      mgmt_rvalid <= mgmt_req.rd && acc_ok;
    end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence cpu_enter_s;
    state == ST_RUN && sleep_en && cpu_mode && wr_sleep && mgmt_req.wdata[`PPM_SL_ENTER];
  endsequence

  sequence asleep_off_s;
    state == ST_SLEEP ##1 !pwr.io_on && !pwr.tx_on && sleep_active;
  endsequence

  psave_rx_off_a: assert property (psave && !energy_detect_power_down && state == ST_RUN // [R2]
    && !basic[`PPM_BASIC_PDOWN] |=> !pwr.rx_on && pwr.tx_on && pwr.energy_det_on && pwr.pll_on)
    else $error("power saving left the receiver running");

  energy_detect_power_down_pll_off_a: assert property (energy_detect_power_down && digctl[`PPM_DIG_PLL_OFF] |=> !pwr.pll_on) // [R4]
    else $error("PLL kept on in energy-detect power down with PLL off");

  pdown_all_off_a: assert property (state == ST_RUN && basic[`PPM_BASIC_PDOWN] // [R6]
    |=> !pwr.tx_on && !pwr.pll_on && !pwr.rx_on && pwr.mgmt_on)
    else $error("power down did not stop the transceiver");

  slow_osc_a: assert property (afe0[`PPM_AFE0_SLOW_OSC] |=> !pwr.ref_clk_connect) // [R7]
    else $error("reference clock still connected in slow oscillator mode");

  cpu_entry_a: assert property (cpu_enter_s |=> asleep_off_s) // [R16]
    else $error("manual sleep entry not taken");

  shadow_gate_a: assert property (wr && reg_hit(mgmt_req, `PPM_REG_AFE2) // [R10]
    && !sleep_ctl[`PPM_SL_SHADOW] |=> $stable(sh_afe2))
    else $error("always-on copy written without access bit");

  ind_forced_a: assert property (!sleep_en |=> line_energy_indicator) // [R14]
    else $error("indicator not held high before enable");

  ind_follow_a: assert property (sleep_en && energy && $stable(sleep_ctl) // [R11]
    |=> ##1 line_energy_indicator == !sleep_ctl[`PPM_SL_POLARITY])
    else $error("indicator did not assert on line energy");

  auto_cycle_a: assert property (state == ST_SLEEP && !cpu_mode && detect // [R20]
    |=> state == ST_RUN ##1 pwr.io_on)
    else $error("automatic wake-up missing");

  auto_enter_a: assert property (state == ST_RUN && sleep_en && !cpu_mode && !detect // [R20]
    |=> state == ST_SLEEP)
    else $error("automatic sleep entry missing");

  wake_write_a: assert property (state == ST_SLEEP && cpu_mode && wr_sleep // [R17]
    |=> state == ST_RUN)
    else $error("register write did not end sleep");

  // Cycles since the last interval tick, and whether that whole span ran in
  // energy-detect power down; a mode change mid-span leaves the gap undefined.
  logic [23:0] tick_gap;
  logic        long_span;

  always_ff @(posedge ref_clk)
    if (!rst_b || lp_tick)
      tick_gap <= 24'h000001;
    else
      tick_gap <= tick_gap + 24'h000001;

  always_ff @(posedge ref_clk)
    if (!rst_b)
      long_span <= 1'b0;
    else if (lp_tick)
      long_span <= energy_detect_power_down;
    else if (!energy_detect_power_down)
      long_span <= 1'b0;

  energy_detect_power_down_interval_a: assert property (lp_tick && long_span |-> tick_gap == LP_ENERGY_DETECT_POWER_DOWN_CYC) // [R5]
    else $error("link pulse interval wrong in energy-detect power down");

  hw_reset_a: assert property ($rose(rst_b) |-> sleep_ctl == `PPM_DEF_SLEEP // [R21]
    && sh_sleep == `PPM_DEF_SLEEP && state == ST_RUN)
    else $error("hardware reset did not restore sleep control");
endmodule : ppm_top
